// ==== hdl/spsdc_cmd.sv ====
// command interpreter: pin pull mask, augmentation mask, datum, position requests
// assumes raw serial bytes arrive in clock domain CLK; report engines sit outside
`timescale 1ns/100ps
module spsdc_cmd (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic [7:0]  RX_BYTE,
  input  wire logic        RX_VALID,
  input  wire logic        STANDBY,
  output logic      [13:0] PULL_UP,
  output logic      [13:0] PULL_EN,
  output logic      [18:0] SBAS_DISABLE,
  output logic      [15:0] DATUM_INDEX,
  output logic             EXT_EN,
  output logic             DATUM_RPT,
  output logic             POS_RPT,
  output logic             POS_AUTO,
  output logic             FLASH_WR,
  output logic      [13:0] FLASH_MASK,
  output logic             FLASH_POS_AUTO,
  input  wire logic [4:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA
);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  logic [7:0]  dec_byte;
  logic        dec_first;
  logic        dec_data;
  logic        dec_end;

  spsdc_frame_dec u_dec (
    .clk       (CLK),
    .rst_n     (RST_N),
    .ce        (CE),
    .in_byte   (RX_BYTE),
    .in_valid  (RX_VALID),
    .out_byte  (dec_byte),
    .out_first (dec_first),
    .out_data  (dec_data),
    .out_end   (dec_end)
  );

  // packet collector: only the first four data bytes are ever needed
  logic [7:0]  pkt_id;
  logic [7:0]  pkt_buf [0:spsdc_pkg::BUF_DEPTH-1];
  logic [2:0]  pkt_len;
  logic        pkt_over;
  logic        pkt_open;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pkt_id   <= 8'h00;
      pkt_len  <= 3'h0;
      pkt_over <= 1'b0;
      pkt_open <= 1'b0;
      for (int i = 0; i < spsdc_pkg::BUF_DEPTH; i++) pkt_buf[i] <= 8'h00;
    end else if (CE) begin
      if (dec_first) begin
        pkt_id   <= dec_byte;
        pkt_len  <= 3'h0;
        pkt_over <= 1'b0;
        pkt_open <= 1'b1;
      end else if (dec_data && pkt_open) begin
        if (pkt_len == spsdc_pkg::LEN_BUF_FULL) begin
          pkt_over <= 1'b1;
        end else begin
          pkt_buf[pkt_len[1:0]] <= dec_byte;
          pkt_len               <= pkt_len + 3'h1;
        end
      end else if (dec_end) begin
        pkt_open <= 1'b0;
      end
    end
  end

  wire        pkt_done  = CE && dec_end && pkt_open;
  wire        len_exact = !pkt_over;
  wire        id_ext    = pkt_id == spsdc_pkg::ID_EXT_CMD;
  wire [7:0]  sub_code  = pkt_buf[0]; // [R9]
  wire [15:0] datum_new = {pkt_buf[1], pkt_buf[2]};
  wire [13:0] stby_new  = {pkt_buf[1][5:0], pkt_buf[0]};
  // mask bytes travel most significant first, so byte 0 lands last
  wire [31:0] sbas_word = {pkt_buf[0], pkt_buf[1], pkt_buf[2], pkt_buf[3]};

  wire do_stby = pkt_done && len_exact && pkt_id == spsdc_pkg::ID_STBY_MASK
                 && pkt_len == spsdc_pkg::LEN_STBY;
  wire do_sbas = pkt_done && len_exact && pkt_id == spsdc_pkg::ID_SBAS_MASK
                 && pkt_len == spsdc_pkg::LEN_SBAS; // [R6]
  wire do_io   = pkt_done && pkt_id == spsdc_pkg::ID_IO_OPTIONS
                 && pkt_len >= spsdc_pkg::LEN_SUB_ONLY;
  wire ext_ok  = pkt_done && len_exact && id_ext; // [R9]
  wire do_datum_q   = ext_ok && sub_code == spsdc_pkg::SUB_DATUM
                      && pkt_len == spsdc_pkg::LEN_SUB_ONLY;
  wire do_datum_set = ext_ok && sub_code == spsdc_pkg::SUB_DATUM
                      && pkt_len == spsdc_pkg::LEN_DATUM_SET
                      && !datum_new[15] && datum_new < spsdc_pkg::DATUM_COUNT;
  wire do_pos_q    = ext_ok && sub_code == spsdc_pkg::SUB_POS_GRID
                     && pkt_len == spsdc_pkg::LEN_SUB_ONLY;
  wire do_pos_mark = ext_ok && sub_code == spsdc_pkg::SUB_POS_GRID
                     && pkt_len == spsdc_pkg::LEN_POS_MARK && pkt_buf[1][7:1] == 7'h00;
  // a longer shutdown packet still carries its save flag in data byte 1
  wire save_shut = pkt_done && pkt_id == spsdc_pkg::ID_SHUTDOWN
                   && pkt_len >= spsdc_pkg::LEN_SHUT_MIN
                   && (pkt_buf[1] == spsdc_pkg::SAVE_USER_A
                       || pkt_buf[1] == spsdc_pkg::SAVE_USER_B);
  wire save_ext  = ext_ok && sub_code == spsdc_pkg::SUB_SAVE
                   && pkt_len == spsdc_pkg::LEN_SUB_ONLY;
  wire do_save   = save_shut || save_ext;
  wire cmd_ok    = do_stby || do_sbas || do_io || do_datum_q || do_datum_set
                   || do_pos_q || do_pos_mark || do_save;
  wire discard   = pkt_done && !cmd_ok; // [R17]

  // stored settings
  logic [13:0] stby_mask;
  logic        pos_auto;
  logic [7:0]  discard_cnt;

  wire reg_ctrl_wr = CE && WR && ADDR == spsdc_pkg::REG_CTRL;
  wire next_ext_en = do_io ? pkt_buf[0][spsdc_pkg::IO_EXT_BIT]
                   : reg_ctrl_wr ? WDATA[spsdc_pkg::CTRL_EXT_BIT] : EXT_EN;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stby_mask    <= spsdc_pkg::STBY_RESET; // [R2]
      SBAS_DISABLE <= '0;
      DATUM_INDEX  <= spsdc_pkg::DATUM_RESET;
      pos_auto     <= 1'b0;
      EXT_EN       <= 1'b0;
      discard_cnt  <= 8'h00;
    end else if (CE) begin
      if (do_stby) stby_mask <= stby_new; // [R2]
      if (do_sbas) SBAS_DISABLE <= sbas_word[spsdc_pkg::SBAS_W-1:0]; // [R8]
      if (do_datum_set) DATUM_INDEX <= datum_new; // [R12] [R13]
      if (do_pos_mark) pos_auto <= pkt_buf[1][0]; // [R15]
      EXT_EN <= next_ext_en;
      if (discard && discard_cnt != 8'hFF) discard_cnt <= discard_cnt + 8'h01;
    end
  end

  assign POS_AUTO = pos_auto;

  // pull drive is registered, so it follows STANDBY one cycle late
  wire [13:0] next_pull_en = STANDBY ? spsdc_pkg::STBY_ALL_EN
                                     : spsdc_pkg::STBY_RUN_EN; // [R1] [R3]

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PULL_UP        <= spsdc_pkg::STBY_RESET;
      PULL_EN        <= spsdc_pkg::STBY_RUN_EN;
      DATUM_RPT      <= 1'b0;
      POS_RPT        <= 1'b0;
      FLASH_WR       <= 1'b0;
      FLASH_MASK     <= spsdc_pkg::STBY_RESET;
      FLASH_POS_AUTO <= 1'b0;
    end else if (CE) begin
      PULL_UP   <= stby_mask; // [R1]
      PULL_EN   <= next_pull_en; // [R3]
      DATUM_RPT <= do_datum_q && EXT_EN; // [R10] [R11]
      POS_RPT   <= do_pos_q && EXT_EN; // [R10] [R14]
      FLASH_WR  <= do_save; // [R5]
      if (do_save) begin
        FLASH_MASK     <= stby_mask; // [R5]
        FLASH_POS_AUTO <= pos_auto;
      end
    end
  end

  // register port: read data valid only in the cycle after RD
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ADDR)
      spsdc_pkg::REG_CTRL:   rd_mux[spsdc_pkg::CTRL_EXT_BIT] = EXT_EN;
      spsdc_pkg::REG_STBY:   rd_mux[spsdc_pkg::STBY_W-1:0] = stby_mask;
      spsdc_pkg::REG_SBAS:   rd_mux[spsdc_pkg::SBAS_W-1:0] = SBAS_DISABLE;
      spsdc_pkg::REG_DATUM: begin
        rd_mux[15:0]                      = DATUM_INDEX;
        rd_mux[spsdc_pkg::DATUM_AUTO_BIT] = pos_auto;
      end
      spsdc_pkg::REG_STATUS: begin
        rd_mux[7:0]                      = discard_cnt;
        rd_mux[spsdc_pkg::STAT_STBY_BIT] = STANDBY;
        rd_mux[spsdc_pkg::STAT_EXT_BIT]  = EXT_EN;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) RDATA <= 32'h0000_0000;
    else if (CE) RDATA <= RD ? rd_mux : 32'h0000_0000;
  end

  // checks
  chk_pull_standby: assert property ( // [R1]
    CE && STANDBY |=> PULL_EN == spsdc_pkg::STBY_ALL_EN && PULL_UP == $past(stby_mask))
    else $error("standby pulls do not follow the mask");

  chk_pull_run_mode: assert property ( // [R3]
    CE && !STANDBY |=> PULL_EN == spsdc_pkg::STBY_RUN_EN)
    else $error("run mode enables pulls other than the standby request pin");

  chk_stby_mask_load: assert property ( // [R2]
    do_stby |=> stby_mask[spsdc_pkg::STBY_REQ_BIT] == $past(pkt_buf[1][5]))
    else $error("standby request pin pull not taken from byte 1 bit 5");

  chk_flash_on_save: assert property ( // [R5]
    CE && !do_save |=> !FLASH_WR && $stable(FLASH_MASK))
    else $error("flash copy changed without a save command");

  chk_sbas_order: assert property ( // [R6] [R8]
    do_sbas |=> SBAS_DISABLE[7:0] == $past(pkt_buf[3])
                && SBAS_DISABLE[18:16] == $past(pkt_buf[1][2:0]))
    else $error("augmentation mask bytes placed in wrong order");

  chk_ext_gate_out: assert property ( // [R10]
    DATUM_RPT || POS_RPT |-> $past(EXT_EN))
    else $error("extended report issued while extended output disabled");

  sequence s_datum_query;
    do_datum_q && EXT_EN;
  endsequence

  chk_datum_report: assert property (s_datum_query |=> DATUM_RPT ##1 !DATUM_RPT or !CE) // [R11]
    else $error("datum query did not give one report pulse");

  chk_datum_select: assert property ( // [R12]
    do_datum_set |=> DATUM_INDEX == $past(datum_new) && DATUM_INDEX < spsdc_pkg::DATUM_COUNT)
    else $error("datum index not switched to the requested value");

  chk_pos_request: assert property (do_pos_q && EXT_EN |=> POS_RPT) // [R14]
    else $error("position request produced no immediate report");

  chk_pos_mark: assert property (do_pos_mark |=> POS_AUTO == $past(pkt_buf[1][0])) // [R15]
    else $error("auto-report mark not set from second byte");

  chk_discard_hold: assert property ( // [R17]
    discard |=> $stable(stby_mask) && $stable(SBAS_DISABLE) && $stable(DATUM_INDEX)
                && $stable(pos_auto))
    else $error("discarded packet changed a stored setting");

  // a frozen clock enable must not let the masks, datum, extended enable, pulls or read data slip
  chk_ce_freeze_all: assert property (
    !CE |=> $stable(stby_mask) && $stable(SBAS_DISABLE) && $stable(DATUM_INDEX)
            && $stable(EXT_EN) && $stable(PULL_UP) && $stable(PULL_EN) && $stable(RDATA))
    else $error("state moved while the clock enable was low");

  chk_stby_mask_all: assert property ( // [R1]
    do_stby |=> stby_mask == $past(stby_new))
    else $error("pin pull mask not loaded from both mask bytes");

  chk_run_req_pull: assert property ( // [R3]
    CE && !STANDBY
    |=> PULL_UP[spsdc_pkg::STBY_REQ_BIT] == $past(stby_mask[spsdc_pkg::STBY_REQ_BIT]))
    else $error("run mode pull of the standby request pin does not follow the mask");

  sequence s_save_pulse;
    FLASH_WR ##1 !FLASH_WR;
  endsequence

  chk_save_snapshot: assert property ( // [R5]
    do_save |=> FLASH_MASK == $past(stby_mask) && FLASH_POS_AUTO == $past(pos_auto))
    else $error("save did not copy the current settings");

  chk_save_one_pulse: assert property (do_save |=> s_save_pulse or !CE) // [R5]
    else $error("save request did not give one flash write pulse");

  chk_ext_enable_set: assert property ( // [R10]
    do_io |=> EXT_EN == $past(pkt_buf[0][spsdc_pkg::IO_EXT_BIT]))
    else $error("extended output enable not taken from the options command");

  chk_ext_query_drop: assert property ( // [R10]
    (do_datum_q || do_pos_q) && !EXT_EN |=> !DATUM_RPT && !POS_RPT)
    else $error("report issued for a query while extended output disabled");

  sequence s_pos_query;
    do_pos_q && EXT_EN;
  endsequence

  chk_pos_one_pulse: assert property (s_pos_query |=> POS_RPT ##1 !POS_RPT or !CE) // [R14]
    else $error("position query did not give one report pulse");

  chk_datum_in_range: assert property ( // [R12]
    DATUM_INDEX < spsdc_pkg::DATUM_COUNT && !DATUM_INDEX[15])
    else $error("datum index outside the stored table");

  chk_pos_mark_only: assert property ( // [R15]
    CE && !do_pos_mark |=> $stable(pos_auto))
    else $error("auto-report mark moved without a mark command");

  chk_discard_count: assert property ( // [R17]
    discard && discard_cnt != 8'hFF |=> discard_cnt == $past(discard_cnt) + 8'h01)
    else $error("discarded packet not counted");

  chk_read_slot: assert property (
    CE && !RD |=> RDATA == 32'h0000_0000)
    else $error("read data shown outside the cycle after a read");

  chk_sbas_hold: assert property ( // [R8]
    CE && !do_sbas |=> $stable(SBAS_DISABLE))
    else $error("augmentation mask changed without a mask command");

endmodule : spsdc_cmd

// ==== inc/spsdc_pkg.sv ====
// constants for the standby-pin / augmentation-mask / datum command interpreter
// assumes one clock domain and packets framed with an escape byte and end-of-text
// Contract
// R1: in standby each masked pin gets pull-down for 0, pull-up for 1
// R2: mask byte 1 bit 5 picks standby request pin pull; reset selects pull-up
// R3: standby request pin pull applies in run mode; others only in standby
// R4: host leaves unconnected pin bits at default pull-down
// R5: pin mask is copied to flash only on the save-configuration command
// R6: augmentation mask is four bytes, 19 PRNs, bit 0 is PRN 120
// R7: host frames mask: escape, id, bytes 3 to 0, escape, end-of-text
// R8: mask bit 1 disables its PRN; all zero enables every satellite
// R9: extended packets use first data byte as sub-code; two-byte identifier
// R10: extended report output only after enable by the I/O options command; code also enables it by a REG_CTRL write
// R11: datum command with sub-code only returns report of datum in use
// R12: datum command with signed 16-bit index selects one of 180 datums
// R13: selected datum is used for every reported position conversion
// R14: position request with sub-code only sends last-data report immediately
// R15: position request second byte 1 marks auto-report, 0 unmarks it
// R16: host sets auto-report then issues save to keep it across power
// R17: packet of undocumented length is discarded, settings unchanged; code accepts longer I/O options and shutdown packets
package spsdc_pkg;

  localparam logic [7:0]  FRAME_ESC      = 8'h10;
  localparam logic [7:0]  FRAME_ETX      = 8'h03;

  localparam logic [7:0]  ID_STBY_MASK   = 8'hC1;
  localparam logic [7:0]  ID_SBAS_MASK   = 8'hC2;
  localparam logic [7:0]  ID_EXT_CMD     = 8'h8E;
  localparam logic [7:0]  ID_IO_OPTIONS  = 8'h35;
  localparam logic [7:0]  ID_SHUTDOWN    = 8'hC0;

  localparam logic [7:0]  SUB_DATUM      = 8'h15;
  localparam logic [7:0]  SUB_POS_GRID   = 8'h17;
  localparam logic [7:0]  SUB_SAVE       = 8'h26;
  localparam logic [7:0]  SAVE_USER_A    = 8'h02;
  localparam logic [7:0]  SAVE_USER_B    = 8'h03;

  localparam int          BUF_DEPTH      = 4;
  localparam logic [2:0]  LEN_SUB_ONLY   = 3'h1;
  localparam logic [2:0]  LEN_STBY       = 3'h2;
  localparam logic [2:0]  LEN_POS_MARK   = 3'h2;
  localparam logic [2:0]  LEN_SHUT_MIN   = 3'h2;
  localparam logic [2:0]  LEN_DATUM_SET  = 3'h3;
  localparam logic [2:0]  LEN_SBAS       = 3'h4;
  localparam logic [2:0]  LEN_BUF_FULL   = 3'h4;

  localparam int          STBY_W         = 14;
  localparam logic [13:0] STBY_RESET     = 14'h2000;
  localparam logic [13:0] STBY_RUN_EN    = 14'h2000;
  localparam logic [13:0] STBY_ALL_EN    = 14'h3FFF;
  localparam int          STBY_REQ_BIT   = 13;

  localparam int          SBAS_W         = 19;
  localparam int          SBAS_PRN_BASE  = 120;
  localparam logic [15:0] DATUM_COUNT    = 16'h00B4;
  localparam logic [15:0] DATUM_RESET    = 16'h0000;
  localparam int          IO_EXT_BIT     = 5;

  localparam int          ADDR_W         = 5;
  localparam logic [4:0]  REG_CTRL       = 5'h00;
  localparam logic [4:0]  REG_STBY       = 5'h04;
  localparam logic [4:0]  REG_SBAS       = 5'h08;
  localparam logic [4:0]  REG_DATUM      = 5'h0C;
  localparam logic [4:0]  REG_STATUS     = 5'h10;
  localparam int          CTRL_EXT_BIT   = 0;
  localparam int          DATUM_AUTO_BIT = 16;
  localparam int          STAT_STBY_BIT  = 8;
  localparam int          STAT_EXT_BIT   = 9;

  typedef enum logic [3:0] {
    DEC_HUNT     = 4'h1,
    DEC_HUNT_ESC = 4'h2,
    DEC_BODY     = 4'h4,
    DEC_BODY_ESC = 4'h8
  } spsdc_dec_t;

endpackage : spsdc_pkg

// ==== hdl/spsdc_frame_dec.sv ====
// frame decoder: strips escape framing and undoubles escaped data bytes
// assumes one received byte per cycle at most, marked by in_valid
`timescale 1ns/100ps
module spsdc_frame_dec (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic [7:0] in_byte,
  input  wire logic       in_valid,
  output logic      [7:0] out_byte,
  output logic            out_first,
  output logic            out_data,
  output logic            out_end
);

  spsdc_pkg::spsdc_dec_t state;
  spsdc_pkg::spsdc_dec_t next_state;
  logic                  emit_first;
  logic                  emit_data;
  logic                  emit_end;

  wire is_esc = in_byte == spsdc_pkg::FRAME_ESC;
  wire is_etx = in_byte == spsdc_pkg::FRAME_ETX;

  always_comb begin
    next_state = state;
    emit_first = 1'b0;
    emit_data  = 1'b0;
    emit_end   = 1'b0;
    if (in_valid) begin
      unique case (state)
        spsdc_pkg::DEC_HUNT: begin
          if (is_esc) next_state = spsdc_pkg::DEC_HUNT_ESC;
        end
        spsdc_pkg::DEC_HUNT_ESC: begin
          if (is_esc || is_etx) begin
            next_state = spsdc_pkg::DEC_HUNT;
          end else begin
            emit_first = 1'b1; // [R7]
            next_state = spsdc_pkg::DEC_BODY;
          end
        end
        spsdc_pkg::DEC_BODY: begin
          if (is_esc) next_state = spsdc_pkg::DEC_BODY_ESC;
          else emit_data = 1'b1;
        end
        spsdc_pkg::DEC_BODY_ESC: begin
          if (is_esc) begin
            emit_data  = 1'b1;
            next_state = spsdc_pkg::DEC_BODY;
          end else if (is_etx) begin
            emit_end   = 1'b1; // [R7]
            next_state = spsdc_pkg::DEC_HUNT;
          end else begin
            // lost end-of-text: the byte after escape opens a new packet
            emit_first = 1'b1;
            next_state = spsdc_pkg::DEC_BODY;
          end
        end
        default: next_state = spsdc_pkg::DEC_HUNT;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= spsdc_pkg::DEC_HUNT;
      out_byte  <= 8'h00;
      out_first <= 1'b0;
      out_data  <= 1'b0;
      out_end   <= 1'b0;
    end else if (ce) begin
      state     <= next_state;
      out_byte  <= in_byte;
      out_first <= emit_first;
      out_data  <= emit_data;
      out_end   <= emit_end;
    end
  end

  sequence s_body_esc;
    ce && in_valid && state == spsdc_pkg::DEC_BODY_ESC;
  endsequence

  chk_frame_end_mark: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
    s_body_esc ##0 is_etx |=> out_end && !out_data && !out_first)
    else $error("end-of-text after escape did not close the packet");

  chk_escaped_data: assert property (@(posedge clk) disable iff (!rst_n)
    s_body_esc ##0 is_esc |=> out_data && out_byte == spsdc_pkg::FRAME_ESC)
    else $error("doubled escape not delivered as one data byte");

endmodule : spsdc_frame_dec

// ==== tb/spsdc_host.sv ====
// host model: frames command packets onto the raw serial byte input
// assumes the caller starts just after a rising edge; one byte per cycle
`timescale 1ns/100ps
module spsdc_host (
  input  wire logic       clk,
  output logic      [7:0] rx_byte,
  output logic            rx_valid
);
  initial begin
    rx_byte  = 8'h00;
    rx_valid = 1'b0;
  end

  task automatic put(input logic [7:0] b);
    rx_byte  <= b;
    rx_valid <= 1'b1;
    @(posedge clk);
  endtask : put

  // escape, id, data with escape bytes doubled, escape, end-of-text
  task automatic send_pkt(input logic [7:0] id, input logic [7:0] d [$]);
    put(spsdc_pkg::FRAME_ESC);
    put(id);
    foreach (d[i]) begin
      put(d[i]);
      if (d[i] == spsdc_pkg::FRAME_ESC) begin
        put(d[i]);
      end
    end
    put(spsdc_pkg::FRAME_ESC);
    put(spsdc_pkg::FRAME_ETX);
    // idle line must not look like a stale valid byte
    rx_valid <= 1'b0;
    rx_byte  <= ~spsdc_pkg::FRAME_ETX;
  endtask : send_pkt
endmodule : spsdc_host

// ==== tb/spsdc_cmd_bench.sv ====
// self-checking bench for the command interpreter
// assumes one 25 MHz clock; the host model feeds framed bytes
`timescale 1ns/100ps
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin miscompares++; \
  $display("wrong value at %0t: got %h want %h", $time, act, exp); end end
module spsdc_cmd_bench;
  logic        clk, rst_n, standby, wr, rd, rd_pend, rx_valid, ce;
  logic        ext_en, datum_rpt, pos_rpt, pos_auto, flash_wr, flash_pos_auto;
  logic [7:0]  rx_byte;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, e_mon;
  logic [13:0] pull_up, pull_en, flash_mask;
  logic [18:0] sbas_dis;
  logic [15:0] datum_idx;
  logic [31:0] exp_q [$];
  int          miscompares, total_checks, cycles, seed;

  spsdc_host host (.clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid));

  spsdc_cmd dut (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .RX_BYTE(rx_byte), .RX_VALID(rx_valid),
    .STANDBY(standby), .PULL_UP(pull_up), .PULL_EN(pull_en), .SBAS_DISABLE(sbas_dis),
    .DATUM_INDEX(datum_idx), .EXT_EN(ext_en), .DATUM_RPT(datum_rpt), .POS_RPT(pos_rpt),
    .POS_AUTO(pos_auto), .FLASH_WR(flash_wr), .FLASH_MASK(flash_mask),
    .FLASH_POS_AUTO(flash_pos_auto), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // run should need well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end

  // strobe gets a quiet cycle after it so no signal is driven twice per step
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
  endtask : rd_reg

  // pulse is {datum report, position report, flash save}; zero means none due
  task automatic pkt(input logic [7:0] id, input logic [7:0] d [$], input logic [2:0] pulse);
    if (pulse != 3'b000) begin
      exp_q.push_back({29'h0, pulse});
    end
    host.send_pkt(id, d);
    repeat (4) @(posedge clk);
    #1;
  endtask : pkt

  // results: read data the cycle after a read, or any report or save pulse
  always @(posedge clk) rd_pend <= rd;
  always @(negedge clk) begin
    if (rst_n && (rd_pend || datum_rpt || pos_rpt || flash_wr)) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("wrong value at %0t: unexpected result", $time);
      end else begin
        e_mon = exp_q.pop_front();
        if (rd_pend) begin
          `CHK(rdata, e_mon)
        end else begin
          `CHK({29'h0, datum_rpt, pos_rpt, flash_wr}, e_mon)
        end
      end
    end
  end

  initial begin
    logic [7:0]  b0, b1;
    logic [13:0] m;
    logic [31:0] sb [4];
    seed    = 32'h9e8a;
    rst_n   = 1'b0;
    ce      = 1'b1;
    standby = 1'b0;
    wr      = 1'b0;
    rd      = 1'b0;
    rd_pend = 1'b0;
    addr    = 5'h00;
    wdata   = 32'h0000_0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(pull_up, spsdc_pkg::STBY_RESET)
    `CHK(pull_en, spsdc_pkg::STBY_RUN_EN)
    `CHK(datum_idx, spsdc_pkg::DATUM_RESET)
    for (int i = 0; i < 2; i++) begin
      // first pass carries an escape-valued data byte
      b0 = (i == 0) ? 8'h10 : (8'($random(seed)) & 8'hFE); // pin 0 left pull-down
      b1 = {2'b00, i[0], 5'($random(seed))};
      m  = {b1[5:0], b0};
      pkt(spsdc_pkg::ID_STBY_MASK, '{b0, b1}, 3'b000);
      `CHK(pull_up, m)
      `CHK(pull_en, spsdc_pkg::STBY_RUN_EN)
      `CHK(flash_mask, spsdc_pkg::STBY_RESET)
      standby <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK(pull_en, spsdc_pkg::STBY_ALL_EN)
      standby <= 1'b0;
      rd_reg(spsdc_pkg::REG_STBY, {18'h0, m});
    end
    pkt(spsdc_pkg::ID_STBY_MASK, '{8'hFF, 8'hFF, 8'hFF}, 3'b000);
    `CHK(pull_up, m)
    pkt(spsdc_pkg::ID_EXT_CMD, '{spsdc_pkg::SUB_SAVE}, 3'b001);
    `CHK(flash_mask, m)
    pkt(spsdc_pkg::ID_STBY_MASK, '{8'h00, 8'h00}, 3'b000);
    `CHK(flash_mask, m)
    pkt(spsdc_pkg::ID_SHUTDOWN, '{8'h53, spsdc_pkg::SAVE_USER_A}, 3'b001);
    `CHK(flash_mask, 14'h0000)
    // PRN 135 alone, PRN 138 alone, all enabled, then a random mask
    sb = '{32'h0000_8000, 32'h0004_0000, 32'h0000_0000, 32'h0000_0000};
    sb[3] = $random(seed);
    foreach (sb[k]) begin
      pkt(spsdc_pkg::ID_SBAS_MASK, '{sb[k][31:24], sb[k][23:16], sb[k][15:8], sb[k][7:0]},
          3'b000);
      `CHK(sbas_dis, sb[k][18:0])
    end
    wr_reg(spsdc_pkg::REG_SBAS, 32'hFFFF_FFFF);
    rd_reg(spsdc_pkg::REG_SBAS, {13'h0, sb[3][18:0]});
    pkt(spsdc_pkg::ID_EXT_CMD, '{spsdc_pkg::SUB_DATUM}, 3'b000);
    pkt(spsdc_pkg::ID_IO_OPTIONS, '{8'h20}, 3'b000);
    `CHK(ext_en, 1'b1)
    pkt(spsdc_pkg::ID_EXT_CMD, '{spsdc_pkg::SUB_DATUM}, 3'b100);
    pkt(spsdc_pkg::ID_EXT_CMD, '{spsdc_pkg::SUB_DATUM, 8'h00, 8'hB3}, 3'b000);
    `CHK(datum_idx, 16'h00B3)
    pkt(spsdc_pkg::ID_EXT_CMD, '{spsdc_pkg::SUB_DATUM, 8'h00, 8'hB4}, 3'b000);
    pkt(spsdc_pkg::ID_EXT_CMD, '{spsdc_pkg::SUB_DATUM, 8'hFF, 8'hFF}, 3'b000);
    `CHK(datum_idx, 16'h00B3)
    pkt(spsdc_pkg::ID_EXT_CMD, '{spsdc_pkg::SUB_POS_GRID}, 3'b010);
    pkt(spsdc_pkg::ID_EXT_CMD, '{spsdc_pkg::SUB_POS_GRID, 8'h01}, 3'b000);
    `CHK(pos_auto, 1'b1)
    pkt(spsdc_pkg::ID_EXT_CMD, '{spsdc_pkg::SUB_POS_GRID, 8'h02}, 3'b000);
    `CHK(pos_auto, 1'b1)
    // set first, then save, as the host must for persistence
    pkt(spsdc_pkg::ID_EXT_CMD, '{spsdc_pkg::SUB_SAVE}, 3'b001);
    `CHK(flash_pos_auto, 1'b1)
    pkt(spsdc_pkg::ID_EXT_CMD, '{spsdc_pkg::SUB_POS_GRID, 8'h00}, 3'b000);
    `CHK(pos_auto, 1'b0)
    rd_reg(spsdc_pkg::REG_DATUM, {16'h0000, 16'h00B3});
    wr_reg(spsdc_pkg::REG_CTRL, 32'h0000_0000);
    // a write while the clock enable is low must be lost
    ce <= 1'b0;
    wr_reg(spsdc_pkg::REG_CTRL, 32'h0000_0001);
    #1;
    `CHK(ext_en, 1'b0)
    ce <= 1'b1;
    pkt(spsdc_pkg::ID_EXT_CMD, '{spsdc_pkg::SUB_POS_GRID}, 3'b000);
    rd_reg(spsdc_pkg::REG_STATUS, {22'h0, 1'b0, 1'b0, 8'h04});
    rd_reg(5'h14, 32'h0000_0000);
    repeat (3) @(posedge clk);
    `CHK(exp_q.size(), 0)
    stop_test();
  end
endmodule : spsdc_cmd_bench
